// >>> hdl/mtcr_regs.sv
// mtcr_regs: test config, memory attribute and target select registers with apb access
// assumes: one clock, apb master holds a request until pready; route and direction come from the executor
//
// How it works
// R1: test config output comes from config register bits 15:0; upper bits reserved.
// R2: only software writes change the three registers; logic never alters them.
// R3: software loads all three registers before setting program run enable.
// R4: row field 26:22 holds row address bits minus two.
// R5: column field 20:18 gives column bits 0..5; codes six and seven reserved.
// R6: write cycle field 17:14 holds cycles per write minus one.
// R7: read cycle field 13:10 holds cycles per read minus one.
// R8: guard path depth 9:5 is pipeline depth for nonzero route.
// R9: direct pipe depth 4:0 is pipeline depth for route zero.
// R10: lower target select bits always come from the bank select field.
// R11: top bits: direct for route 0, generation on write route 1, direct on writes to routes 2 and 3.
// R12: reads use error-check, syndrome, correction fields for routes 1, 2, 3.
// R13: target select layout 17:16,15:14,13:12,11:10,9:8,7:0; 31:18 reserved.
// R14: bank select field width is target select width minus two.
// R15: one-bit unit section: software uses low bit as top bit.
// R16: two-bit unit section: software selects unit with both bits, direct zero.
// R17: target select leaves in the same cycle as address and route.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/100ps
module mtcr_regs
	import mtcr_pkg::*;
#(
	parameter int TSEL_W = 10, // target_select_width_param
	parameter int ADDR_W = 32 // test address width
) (
	input wire logic i_sys_clk, // system clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb enable
	input wire logic i_pwrite, // apb direction
	input wire logic [7:0] i_paddr, // apb byte address
	input wire logic [31:0] i_pwdata, // apb write data
	output logic [31:0] o_prdata, // apb read data
	output logic o_pready, // apb ready
	output logic o_pslverr, // apb error
	input wire logic i_txn_valid, // executor issues a transaction
	input wire logic i_txn_write, // executor transaction is a write
	input wire logic [1:0] i_txn_route, // executor path route
	input wire logic [ADDR_W-1:0] i_txn_addr, // executor address
	output logic [MTCR_CFG_W-1:0] o_test_config_out, // test configuration output
	output logic [TSEL_W-1:0] o_target_select_out, // target select output
	output logic [1:0] o_path_route_out, // path route output
	output logic [ADDR_W-1:0] o_test_address_out, // test address output
	output logic o_txn_write_out, // write strobe toward memory
	output logic o_txn_valid_out, // transaction valid toward memory
	output logic [3:0] o_write_cycle_count, // cycles per write minus one
	output logic [3:0] o_read_cycle_count, // cycles per read minus one
	output logic [4:0] o_guard_path_depth, // pipeline depth, nonzero route
	output logic [4:0] o_direct_pipe_depth, // pipeline depth, route zero
	output logic [5:0] o_row_bits, // row address bits
	output logic [2:0] o_column_bits_setting // column bits
);
	// ----------------------------------------
	// parameter checks
	// ----------------------------------------
	localparam int BANK_W = TSEL_W - 2; // R14
	if (TSEL_W < 3 || BANK_W > MTCR_TS_BANK_W) begin : g_tsel_w_bad
		$error("target select width must be 3 to 10");
	end
	if (ADDR_W < 1 || ADDR_W > 32) begin : g_addr_w_bad
		$error("address width must be 1 to 32");
	end

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	logic [31:0] cfg_q;
	logic [31:0] mem_q;
	logic [31:0] tsel_q;
	logic [31:0] tsel_mask;
	logic wr_acc;
	logic rd_acc;
	logic hit;
	logic col_bad;
	logic [5:0] row_bits;
	logic [1:0] unit_sel;
	logic [31:0] rdata_d;

	assign tsel_mask = MTCR_TSEL_MASK & ~((32'hFF << BANK_W) & 32'h000000FF); // R13 R14
	assign hit = (i_paddr == MTCR_OFF_CFG) || (i_paddr == MTCR_OFF_MEM) ||
		(i_paddr == MTCR_OFF_TSEL) || (i_paddr == MTCR_OFF_STAT);
	// writes land at the end of the access phase, when the master sees pready
	assign wr_acc = i_psel && i_penable && i_pwrite && o_pready;
	assign rd_acc = i_psel && !i_penable && !i_pwrite;

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cfg_q <= MTCR_RST_VAL;
			mem_q <= MTCR_RST_VAL;
			tsel_q <= MTCR_RST_VAL;
		end else if (wr_acc) begin
			// only bus writes reach these flops
			case (i_paddr) // R2
				MTCR_OFF_CFG: cfg_q <= i_pwdata & MTCR_CFG_MASK; // R1
				MTCR_OFF_MEM: mem_q <= i_pwdata & MTCR_MEM_MASK; // R4 R5 R6 R7 R8 R9
				MTCR_OFF_TSEL: tsel_q <= i_pwdata & tsel_mask; // R13
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// apb answer: one wait-free access phase
	// ----------------------------------------
	always_comb begin
		case (i_paddr)
			MTCR_OFF_CFG: rdata_d = cfg_q;
			MTCR_OFF_MEM: rdata_d = mem_q;
			MTCR_OFF_TSEL: rdata_d = tsel_q;
			MTCR_OFF_STAT: rdata_d = {25'h0, col_bad, row_bits};
			default: rdata_d = 32'h0;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_prdata <= 32'h0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel && !i_penable;
			o_pslverr <= i_psel && !i_penable && !hit;
			if (rd_acc) begin
				o_prdata <= rdata_d;
			end
		end
	end

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	mtcr_field_check u_check (
		.i_mem_reg(mem_q),
		.o_col_bad(col_bad),
		.o_row_bits(row_bits)
	);

	mtcr_tsel_mux u_mux (
		.i_tsel_reg(tsel_q),
		.i_route(i_txn_route),
		.i_write(i_txn_write),
		.o_unit(unit_sel)
	);

	// ----------------------------------------
	// static outputs
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_test_config_out <= '0;
			o_write_cycle_count <= 4'h0;
			o_read_cycle_count <= 4'h0;
			o_guard_path_depth <= 5'h00;
			o_direct_pipe_depth <= 5'h00;
			o_row_bits <= 6'h00;
			o_column_bits_setting <= 3'h0;
		end else begin
			o_test_config_out <= cfg_q[MTCR_CFG_W-1:0]; // R1
			o_write_cycle_count <= mem_q[MTCR_WCYC_HI:MTCR_WCYC_LO]; // R6
			o_read_cycle_count <= mem_q[MTCR_RCYC_HI:MTCR_RCYC_LO]; // R7
			o_guard_path_depth <= mem_q[MTCR_GDEP_HI:MTCR_GDEP_LO]; // R8
			o_direct_pipe_depth <= mem_q[MTCR_DDEP_HI:MTCR_DDEP_LO]; // R9
			o_row_bits <= row_bits; // R4
			o_column_bits_setting <= mem_q[MTCR_COL_HI:MTCR_COL_LO]; // R5
		end
	end

	// ----------------------------------------
	// transaction outputs, all one stage
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_target_select_out <= '0;
			o_path_route_out <= 2'h0;
			o_test_address_out <= '0;
			o_txn_write_out <= 1'b0;
			o_txn_valid_out <= 1'b0;
		end else begin
			// same register stage for address, route and target select
			o_target_select_out <= {unit_sel, tsel_q[BANK_W-1:0]}; // R10 R11 R12 R17
			o_path_route_out <= i_txn_route; // R17
			o_test_address_out <= i_txn_addr; // R17
			o_txn_write_out <= i_txn_write;
			o_txn_valid_out <= i_txn_valid;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_cfg_out;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		1'b1 |=> o_test_config_out == $past(cfg_q[15:0]);
	endproperty
	a_cfg_out: assert property (p_cfg_out) else $error("config output mismatch"); // R1

	property p_hold;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!wr_acc |=> $stable(cfg_q) && $stable(mem_q) && $stable(tsel_q);
	endproperty
	a_hold: assert property (p_hold) else $error("register changed without write"); // R2

	property p_row;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		1'b1 |-> row_bits == 6'(mem_q[26:22]) + 6'h2;
	endproperty
	a_row: assert property (p_row) else $error("row bits decode wrong"); // R4

	property p_col;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		col_bad == (mem_q[20:18] >= 3'h6);
	endproperty
	a_col: assert property (p_col) else $error("column reserved flag wrong"); // R5

	property p_wcyc;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		wr_acc && i_paddr == MTCR_OFF_MEM ##1 !wr_acc ##1 1'b1 |-> o_write_cycle_count == mem_q[17:14];
	endproperty
	a_wcyc: assert property (p_wcyc) else $error("write cycle count wrong"); // R6

	property p_rcyc;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		1'b1 |=> o_read_cycle_count == $past(mem_q[13:10]);
	endproperty
	a_rcyc: assert property (p_rcyc) else $error("read cycle count wrong"); // R7

	property p_depths;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		1'b1 |=> o_guard_path_depth == $past(mem_q[9:5]) && o_direct_pipe_depth == $past(mem_q[4:0]);
	endproperty
	a_depths: assert property (p_depths) else $error("pipe depth wrong"); // R8 R9

	property p_bank;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		1'b1 |=> o_target_select_out[BANK_W-1:0] == $past(tsel_q[BANK_W-1:0]);
	endproperty
	a_bank: assert property (p_bank) else $error("bank select bits wrong"); // R10

	property p_wr_gen;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_txn_write && i_txn_route == 2'h1 |=> o_target_select_out[TSEL_W-1 -: 2] == $past(tsel_q[11:10]);
	endproperty
	a_wr_gen: assert property (p_wr_gen) else $error("generation field not used on write"); // R11

	property p_rd_corr;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!i_txn_write && i_txn_route == 2'h3 |=> o_target_select_out[TSEL_W-1 -: 2] == $past(tsel_q[17:16]);
	endproperty
	a_rd_corr: assert property (p_rd_corr) else $error("correction field not used on read"); // R12

	property p_rd_synd;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!i_txn_write && i_txn_route == 2'h2 |=> o_target_select_out[TSEL_W-1 -: 2] == $past(tsel_q[15:14]);
	endproperty
	a_rd_synd: assert property (p_rd_synd) else $error("syndrome field not used on read"); // R12

	property p_reserved;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		tsel_q[31:18] == 14'h0 && cfg_q[31:16] == 16'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits set"); // R13 R14

	property p_align;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		1'b1 |=> o_test_address_out == $past(i_txn_addr) && o_path_route_out == $past(i_txn_route);
	endproperty
	a_align: assert property (p_align) else $error("address and route not aligned"); // R17

	property p_rd_echk;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		!i_txn_write && i_txn_route == 2'h1 |=> o_target_select_out[TSEL_W-1 -: 2] == $past(tsel_q[13:12]);
	endproperty
	a_rd_echk: assert property (p_rd_echk) else $error("error-check field not used on read"); // R12

	property p_dir_route;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_txn_route == 2'h0 |=> o_target_select_out[TSEL_W-1 -: 2] == $past(tsel_q[9:8]);
	endproperty
	a_dir_route: assert property (p_dir_route) else $error("direct field not used on route zero"); // R11

	property p_wr_dir;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_txn_write && i_txn_route[1] |=> o_target_select_out[TSEL_W-1 -: 2] == $past(tsel_q[9:8]);
	endproperty
	a_wr_dir: assert property (p_wr_dir) else $error("direct field not used on upper route write"); // R11

	property p_unused;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(tsel_q & ~tsel_mask) == 32'h0 && (mem_q & ~MTCR_MEM_MASK) == 32'h0;
	endproperty
	a_unused: assert property (p_unused) else $error("unused register bits set"); // R14

	property p_strobes;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		1'b1 |=> o_txn_write_out == $past(i_txn_write) && o_txn_valid_out == $past(i_txn_valid);
	endproperty
	a_strobes: assert property (p_strobes) else $error("transaction strobes not aligned"); // R17

	property p_row_out;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		1'b1 |=> o_row_bits == $past(row_bits);
	endproperty
	a_row_out: assert property (p_row_out) else $error("row bits output wrong"); // R4

	property p_col_out;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		1'b1 |=> o_column_bits_setting == $past(mem_q[20:18]);
	endproperty
	a_col_out: assert property (p_col_out) else $error("column bits output wrong"); // R5

	property p_cfg_wr;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		wr_acc && i_paddr == MTCR_OFF_CFG |=> cfg_q == {16'h0, $past(i_pwdata[15:0])};
	endproperty
	a_cfg_wr: assert property (p_cfg_wr) else $error("config write did not land"); // R1

	property p_mem_wr;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		wr_acc && i_paddr == MTCR_OFF_MEM |=> mem_q == ($past(i_pwdata) & MTCR_MEM_MASK);
	endproperty
	a_mem_wr: assert property (p_mem_wr) else $error("memory attribute write did not land"); // R4 R5 R6 R7 R8 R9

	property p_tsel_wr;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		wr_acc && i_paddr == MTCR_OFF_TSEL |=> tsel_q == ($past(i_pwdata) & tsel_mask);
	endproperty
	a_tsel_wr: assert property (p_tsel_wr) else $error("target select write did not land"); // R13

	property p_tsel_rd;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		rd_acc && i_paddr == MTCR_OFF_TSEL |=> o_prdata == $past(tsel_q);
	endproperty
	a_tsel_rd: assert property (p_tsel_rd) else $error("target select read back wrong"); // R13

	property p_status_rd;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		rd_acc && i_paddr == MTCR_OFF_STAT |=> o_prdata == {25'h0, $past(col_bad), $past(row_bits)};
	endproperty
	a_status_rd: assert property (p_status_rd) else $error("status read back wrong"); // R4 R5
endmodule

// >>> hdl/mtcr_pkg.sv
// mtcr_pkg: register offsets, field positions and codes for the target config registers
// assumes: apb slave with 32-bit data, one aligned word per register
package mtcr_pkg;
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] MTCR_OFF_CFG = 8'h00;
	localparam logic [7:0] MTCR_OFF_MEM = 8'h04;
	localparam logic [7:0] MTCR_OFF_TSEL = 8'h08;
	localparam logic [7:0] MTCR_OFF_STAT = 8'h0C;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int MTCR_CFG_W = 16;
	localparam int MTCR_ROW_LO = 22;
	localparam int MTCR_ROW_HI = 26;
	localparam int MTCR_COL_LO = 18;
	localparam int MTCR_COL_HI = 20;
	localparam int MTCR_WCYC_LO = 14;
	localparam int MTCR_WCYC_HI = 17;
	localparam int MTCR_RCYC_LO = 10;
	localparam int MTCR_RCYC_HI = 13;
	localparam int MTCR_GDEP_LO = 5;
	localparam int MTCR_GDEP_HI = 9;
	localparam int MTCR_DDEP_LO = 0;
	localparam int MTCR_DDEP_HI = 4;
	localparam int MTCR_TS_CORR_LO = 16;
	localparam int MTCR_TS_SYND_LO = 14;
	localparam int MTCR_TS_ECHK_LO = 12;
	localparam int MTCR_TS_GEN_LO = 10;
	localparam int MTCR_TS_DIR_LO = 8;
	localparam int MTCR_TS_BANK_W = 8;
	// ----------------------------------------
	// writable masks and reset values
	// ----------------------------------------
	localparam logic [31:0] MTCR_CFG_MASK = 32'h0000FFFF;
	localparam logic [31:0] MTCR_MEM_MASK = 32'h07DFFFFF;
	localparam logic [31:0] MTCR_TSEL_MASK = 32'h0003FFFF;
	localparam logic [31:0] MTCR_RST_VAL = 32'h00000000;
	localparam logic [2:0] MTCR_COL_MAX = 3'h5;
	localparam int MTCR_ROW_BIAS = 2;
	// ----------------------------------------
	// path-route codes
	// ----------------------------------------
	localparam logic [1:0] MTCR_ROUTE_DIRECT = 2'h0;
	localparam logic [1:0] MTCR_ROUTE_ECHK = 2'h1;
	localparam logic [1:0] MTCR_ROUTE_SYND = 2'h2;
	localparam logic [1:0] MTCR_ROUTE_CORR = 2'h3;
endpackage

// >>> hdl/mtcr_tsel_mux.sv
// mtcr_tsel_mux: picks the protection-unit bits of the target select per route and direction
// assumes: target select register fields are stable while a test runs
`timescale 1ns/100ps
module mtcr_tsel_mux
	import mtcr_pkg::*;
(
	input wire logic [31:0] i_tsel_reg, // target select register
	input wire logic [1:0] i_route, // path route code
	input wire logic i_write, // 1 write, 0 read
	output logic [1:0] o_unit // top two target select bits
);
	function automatic logic [1:0] fld(input logic [31:0] r, input int lo);
		fld = r[lo +: 2];
	endfunction

	always_comb begin
		o_unit = fld(i_tsel_reg, MTCR_TS_DIR_LO);
		if (i_route == MTCR_ROUTE_DIRECT) begin
			o_unit = fld(i_tsel_reg, MTCR_TS_DIR_LO); // R11
		end else if (i_write) begin
			if (i_route == MTCR_ROUTE_ECHK) begin
				o_unit = fld(i_tsel_reg, MTCR_TS_GEN_LO); // R11
			end else begin
				o_unit = fld(i_tsel_reg, MTCR_TS_DIR_LO); // R11
			end
		end else begin
			case (i_route)
				MTCR_ROUTE_ECHK: o_unit = fld(i_tsel_reg, MTCR_TS_ECHK_LO); // R12
				MTCR_ROUTE_SYND: o_unit = fld(i_tsel_reg, MTCR_TS_SYND_LO); // R12
				MTCR_ROUTE_CORR: o_unit = fld(i_tsel_reg, MTCR_TS_CORR_LO); // R12
				default: o_unit = fld(i_tsel_reg, MTCR_TS_DIR_LO);
			endcase
		end
	end
endmodule

// >>> hdl/mtcr_field_check.sv
// mtcr_field_check: flags reserved codes in the memory attribute register
// assumes: value is the stored register content
`timescale 1ns/100ps
module mtcr_field_check
	import mtcr_pkg::*;
(
	input wire logic [31:0] i_mem_reg, // memory attribute register
	output logic o_col_bad, // column code 6 or 7
	output logic [5:0] o_row_bits // decoded row address bits
);
	always_comb begin
		o_col_bad = i_mem_reg[MTCR_COL_HI:MTCR_COL_LO] > MTCR_COL_MAX; // R5
		o_row_bits = 6'(i_mem_reg[MTCR_ROW_HI:MTCR_ROW_LO]) + 6'(MTCR_ROW_BIAS); // R4
	end
endmodule

// >>> test/mtcr_mem_model.sv
// mtcr_mem_model: far-side stand-in for the memory under test, records each transaction
// assumes: transaction outputs are registered and qualified by the valid strobe
`timescale 1ns/100ps
module mtcr_mem_model #(
	parameter int TSEL_W = 10 // target select width
) (
	input wire logic i_sys_clk, // system clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic i_txn_valid, // transaction valid
	input wire logic [1:0] i_path_route, // path route
	input wire logic [TSEL_W-1:0] i_target_select, // target select
	output logic [TSEL_W+1:0] o_last, // route and target select of last transaction
	output logic [7:0] o_count // transactions seen
);
	// route and target select are only meaningful together, in the valid cycle
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_last <= '0;
			o_count <= 8'h00;
		end else if (i_txn_valid) begin
			o_last <= {i_path_route, i_target_select};
			o_count <= o_count + 8'h01;
		end
	end
endmodule

// >>> test/mtcr_regs_test.sv
// mtcr_regs_test: self-checking bench for the target config register bank
// assumes: apb slave answers by itself, transaction outputs follow the inputs by one edge
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module mtcr_regs_test import mtcr_pkg::*;;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tx_valid = 1'b0, tx_write = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, tx_addr = 32'h00000000;
	logic [1:0] tx_route = 2'h0;
	logic [31:0] prdata, addr_o, rd;
	logic pready, pslverr, txw_o, txv_o, er;
	logic [15:0] cfg_o;
	logic [9:0] tsel_o;
	logic [1:0] route_o;
	logic [3:0] wcyc_o, rcyc_o;
	logic [4:0] gdep_o, ddep_o;
	logic [5:0] row_o;
	logic [2:0] col_o;
	logic [11:0] mem_last;
	logic [7:0] mem_cnt;
	int err_count = 0, compares = 0, cycles = 0;
	// {target select reg, route, write, expected target select output}
	logic [44:0] rows [14] = '{
		{32'h00039CA5, 2'h0, 1'b0, 10'h0A5}, {32'h00039CA5, 2'h0, 1'b1, 10'h0A5},
		{32'h00039CA5, 2'h1, 1'b1, 10'h3A5}, {32'h00039CA5, 2'h1, 1'b0, 10'h1A5},
		{32'h00039CA5, 2'h2, 1'b0, 10'h2A5}, {32'h00039CA5, 2'h3, 1'b0, 10'h3A5},
		{32'h00039CA5, 2'h2, 1'b1, 10'h0A5}, {32'h00039CA5, 2'h3, 1'b1, 10'h0A5},
		{32'h0000025A, 2'h0, 1'b0, 10'h25A}, {32'h0000025A, 2'h0, 1'b1, 10'h25A},
		{32'h0000025A, 2'h1, 1'b1, 10'h05A}, {32'h0000025A, 2'h2, 1'b1, 10'h25A},
		{32'h0000025A, 2'h3, 1'b1, 10'h25A}, {32'h0000025A, 2'h3, 1'b0, 10'h05A}
	};

	mtcr_regs #(.TSEL_W(10), .ADDR_W(32)) dut (
		.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_txn_valid(tx_valid), .i_txn_write(tx_write),
		.i_txn_route(tx_route), .i_txn_addr(tx_addr), .o_test_config_out(cfg_o),
		.o_target_select_out(tsel_o), .o_path_route_out(route_o), .o_test_address_out(addr_o),
		.o_txn_write_out(txw_o), .o_txn_valid_out(txv_o), .o_write_cycle_count(wcyc_o),
		.o_read_cycle_count(rcyc_o), .o_guard_path_depth(gdep_o), .o_direct_pipe_depth(ddep_o),
		.o_row_bits(row_o), .o_column_bits_setting(col_o)
	);

	mtcr_mem_model #(.TSEL_W(10)) u_mem (
		.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_txn_valid(txv_o), .i_path_route(route_o),
		.i_target_select(tsel_o), .o_last(mem_last), .o_count(mem_cnt)
	);

	initial forever #2 i_sys_clk = ~i_sys_clk;

	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			err_count++;
			end_sim();
		end
	end

	// one apb transfer; read data and error land in rd and er
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_sys_clk);
		penable <= 1'b1;
		do @(posedge i_sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic tx(input logic [1:0] r, input logic w, input logic [31:0] a);
		@(posedge i_sys_clk);
		tx_valid <= 1'b1;
		tx_write <= w;
		tx_route <= r;
		tx_addr <= a;
		@(posedge i_sys_clk);
		tx_valid <= 1'b0;
		#1;
	endtask

	task automatic end_sim();
		$display("compares=%0d mismatches=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge i_sys_clk);
		`CHK({cfg_o, tsel_o, txv_o}, 27'h0000000)
		i_rst_n <= 1'b1;
		apb(1'b0, MTCR_OFF_TSEL, 32'h00000000);
		`CHK({rd, er}, 33'h000000000)
		$display("test reset done");
		apb(1'b1, MTCR_OFF_CFG, 32'hFFFF1234);
		apb(1'b0, MTCR_OFF_CFG, 32'h00000000);
		`CHK(rd, 32'h00001234)
		`CHK(cfg_o, 16'h1234)
		$display("test config done");
		apb(1'b1, MTCR_OFF_MEM, 32'hFFFFFFFF);
		apb(1'b0, MTCR_OFF_MEM, 32'h00000000);
		`CHK(rd, 32'h07DFFFFF)
		`CHK({wcyc_o, rcyc_o, gdep_o, ddep_o}, 18'h3FFFF)
		`CHK({row_o, col_o}, 9'h10F)
		apb(1'b0, MTCR_OFF_STAT, 32'h00000000);
		`CHK(rd, 32'h00000061)
		apb(1'b1, MTCR_OFF_MEM, 32'h00140CA3);
		apb(1'b0, MTCR_OFF_STAT, 32'h00000000);
		`CHK(rd, 32'h00000002)
		`CHK({wcyc_o, rcyc_o, gdep_o, ddep_o}, 18'h00CA3)
		`CHK({row_o, col_o}, 9'h015)
		apb(1'b1, MTCR_OFF_MEM, 32'h00180000);
		apb(1'b0, MTCR_OFF_STAT, 32'h00000000);
		`CHK(rd, 32'h00000042)
		$display("test memory attributes done");
		apb(1'b1, MTCR_OFF_TSEL, 32'hFFFFFFFF);
		apb(1'b0, MTCR_OFF_TSEL, 32'h00000000);
		`CHK(rd, 32'h0003FFFF)
		// all registers loaded before any transaction is issued
		for (int i = 0; i < 14; i++) begin
			apb(1'b1, MTCR_OFF_TSEL, rows[i][44:13]);
			tx(rows[i][12:11], rows[i][10], 32'h00001000 + 32'(i));
			`CHK(tsel_o, rows[i][9:0])
			`CHK({route_o, txv_o, txw_o}, {rows[i][12:11], 1'b1, rows[i][10]})
			`CHK(addr_o, 32'h00001000 + 32'(i))
		end
		@(posedge i_sys_clk);
		#1;
		`CHK({mem_last, mem_cnt}, {12'hC5A, 8'h0E})
		$display("test target select done");
		apb(1'b0, MTCR_OFF_CFG, 32'h00000000);
		`CHK(rd, 32'h00001234)
		apb(1'b0, MTCR_OFF_MEM, 32'h00000000);
		`CHK(rd, 32'h00180000)
		apb(1'b0, MTCR_OFF_TSEL, 32'h00000000);
		`CHK(rd, 32'h0000025A)
		$display("test hold done");
		apb(1'b1, 8'h10, 32'hFFFFFFFF);
		`CHK(er, 1'b1)
		apb(1'b0, 8'h10, 32'h00000000);
		`CHK({rd, er}, 33'h000000001)
		apb(1'b0, MTCR_OFF_CFG, 32'h00000000);
		`CHK({rd, er}, 33'h000002468)
		$display("test unmapped done");
		end_sim();
	end
endmodule
